/* File: bench/mem_model.sv */
// Memory-side responder that finishes each granted access after a set latency.
// Assumes a grant stands until the cycle after done has been seen.

// ****************************************************************
// Memory responder
// ****************************************************************
module mem_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic mem_host_gnt,
  input wire logic mem_reader_gnt,
  input wire logic [3:0] latency,
  output logic mem_done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] count_reg;

  // Count busy cycles, then one done pulse; never counts during the pulse
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_reg <= 4'h0;
      mem_done <= 1'b0;
    end
    else if ((mem_host_gnt || mem_reader_gnt) && !mem_done && count_reg != latency)
      count_reg <= count_reg + 4'h1;
    else
    begin
      mem_done <= (mem_host_gnt || mem_reader_gnt) && !mem_done;
      count_reg <= 4'h0;
    end
  end
endmodule : mem_model

/* File: bench/tag_bank_chk.sv */
// Port-level checker for the configuration bank.
// Assumes it is bound to the bank's top module; sees only its ports.

// ****************************************************************
// Checker
// ****************************************************************
module tag_bank_chk (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic host_req,
  input wire logic host_write,
  input wire logic host_mode_only,
  input wire logic [2:0] host_index,
  input wire logic [7:0] host_wdata,
  input wire logic host_grant,
  input wire logic rd_blk_write,
  input wire logic rd_blk_locked,
  input wire logic rd_blk_allow,
  input wire logic tag_selected,
  input wire logic authenticated,
  input wire logic mem_host_gnt,
  input wire logic mem_reader_gnt,
  input wire logic frame_crc_ok,
  input wire logic crc_error,
  input wire logic [15:0] sens_res,
  input wire logic [7:0] sel_res_level1,
  input wire logic [7:0] sel_res_level2,
  input wire logic [6:0] i2c_address,
  input wire logic crc_store,
  input wire logic [5:0] msg_max_len,
  input wire tag_cfg_pkg::comm_mode_e comm_mode
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Host is never held off
  a_host_always_served: assert property (host_grant == host_req)
    else $error("host grant differs from request");
  a_sens_high_byte: assert property (host_req && host_write && !host_mode_only
    && host_index == 3'h2 |=> sens_res[15:8] == $past(host_wdata))
    else $error("request answer high byte not updated");
  a_cascade_bits: assert property (sel_res_level1[2] && !sel_res_level2[2])
    else $error("cascade bit wrong");
  a_lock_over_auth: assert property (rd_blk_write && rd_blk_locked |-> !rd_blk_allow)
    else $error("locked block write allowed");
  a_i2c_group: assert property (i2c_address[6:3] == 4'hA)
    else $error("address group wrong");
  a_msg_length: assert property (msg_max_len == (crc_store ? 6'h1E : 6'h20))
    else $error("message length wrong");
  // Past values are only trusted once a full cycle out of reset has passed
  a_crc_always_checked: assert property ($past(rst_n) |-> crc_error == !$past(frame_crc_ok))
    else $error("crc flag wrong");
  a_deselect_deauth: assert property (!tag_selected |=> !authenticated)
    else $error("authentication kept after deselect");
  a_tunnel_first: assert property (host_req && host_write && host_index == 3'h7
    && host_wdata[6] |=> comm_mode == tag_cfg_pkg::mode_tunnel)
    else $error("tunnel mode not chosen");
  a_grant_exclusive: assert property (!(mem_host_gnt && mem_reader_gnt))
    else $error("both memory grants");
endmodule : tag_bank_chk

bind tag_config_and_auth_bank tag_bank_chk u_tag_bank_chk (.clock, .rst_n, .host_req,
  .host_write, .host_mode_only, .host_index, .host_wdata, .host_grant, .rd_blk_write,
  .rd_blk_locked, .rd_blk_allow, .tag_selected, .authenticated, .mem_host_gnt,
  .mem_reader_gnt, .frame_crc_ok, .crc_error, .sens_res, .sel_res_level1, .sel_res_level2,
  .i2c_address, .crc_store, .msg_max_len, .comm_mode);

/* File: bench/test_tag_config_and_auth_bank.sv */
// Self-checking bench for the configuration bank, with a byte model in an unpacked array and flags.
// Assumes the checker is bound separately and the memory responder model is compiled.
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end

// ****************************************************************
// Testbench
// ****************************************************************
module test_tag_config_and_auth_bank;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] LB = 8'h7F;
  logic clock = 0, rst_n = 0, host_req = 0, host_write = 0, host_mode_only = 0;
  logic rd_cfg_req = 0, rd_cfg_write = 0, rd_blk_write = 0, rd_blk_locked = 0;
  logic auth_pass = 0, tag_selected = 0, field_present = 0, io_supply_pin = 1;
  logic mem_host_req = 0, mem_reader_req = 0, frame_crc_ok = 1;
  logic [2:0] host_index = 0, rd_cfg_index = 0;
  logic [7:0] host_wdata = 0, rd_cfg_wdata = 0, rd_blk_addr = 0, rd_blk_data = 0;
  logic [3:0] latency = 0;
  logic host_grant, rd_cfg_ok, rd_blk_allow, authenticated, reader_mute, mem_done;
  logic mem_host_gnt, mem_reader_gnt, crc_error, crc_store, nak_on_error;
  logic [7:0] host_rdata, rd_cfg_rdata, rd_blk_out, sel_res_level1, sel_res_level2;
  logic [15:0] sens_res;
  logic [6:0] i2c_address;
  logic [2:0] quiet_threshold_code;
  logic [5:0] msg_max_len;
  tag_cfg_pkg::comm_mode_e comm_mode;
  tag_cfg_pkg::power_mode_e power_mode;
  // Byte model starts from the documented reset values
  logic [7:0] bank [8] = '{8'hFF, 8'h00, 8'h00, 8'h44, 8'h00, 8'h00, 8'h00, 8'h80};
  logic tun = 0, ext = 0, au = 0;
  int mismatches = 0, n_checks = 0;

  always #25 clock = ~clock;
  // Random frame status every cycle, watched by the checker
  always @(posedge clock) #2 frame_crc_ok = 1'($urandom);

  tag_config_and_auth_bank #(.LAST_BLOCK(LB)) u_tag_config_and_auth_bank (.clock, .rst_n,
    .host_req, .host_write, .host_mode_only, .host_index, .host_wdata, .host_grant,
    .host_rdata, .rd_cfg_req, .rd_cfg_write, .rd_cfg_index, .rd_cfg_wdata, .rd_cfg_ok,
    .rd_cfg_rdata, .rd_blk_addr, .rd_blk_write, .rd_blk_locked, .rd_blk_data, .rd_blk_allow,
    .rd_blk_out, .auth_pass, .tag_selected, .field_present, .io_supply_pin, .authenticated,
    .reader_mute, .mem_host_req, .mem_reader_req, .mem_done, .mem_host_gnt, .mem_reader_gnt,
    .frame_crc_ok, .sens_res, .sel_res_level1, .sel_res_level2, .i2c_address,
    .quiet_threshold_code, .crc_store, .msg_max_len, .crc_error, .nak_on_error, .comm_mode,
    .power_mode);
  mem_model u_mem_model (.clock, .rst_n, .mem_host_gnt, .mem_reader_gnt, .latency, .mem_done);

  task summarize;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize

  // One host cycle; volatile mode copies follow every index 7 write
  task automatic host(input logic w, input logic mo, input logic [2:0] i, input logic [7:0] d);
    @(posedge clock) #2;
    host_req = 1;
    host_write = w;
    host_mode_only = mo;
    host_index = i;
    host_wdata = d;
    @(posedge clock) #2;
    host_req = 0;
    if (!w) `CHK("host_rdata", bank[i], host_rdata)
    else if (!mo || i != 3'h7) bank[i] = d;
    if (w && i == 3'h7) {tun, ext} = d[6:5];
  endtask : host

  task automatic check_outs;
    `CHK("sens_res", {bank[2], bank[3]}, sens_res)
    `CHK("sel1", bank[4] | 8'h04, sel_res_level1)
    `CHK("sel2", (bank[4] & 8'hFB) ^ {1'b0, bank[7][2], 6'h00}, sel_res_level2)
    `CHK("i2c", {4'hA, bank[5][2:0]}, i2c_address)
    `CHK("quiet", bank[5][6:4], quiet_threshold_code)
    `CHK("len", bank[6][7] ? 6'h1E : 6'h20, msg_max_len)
    `CHK("crc_store", bank[6][7], crc_store)
    `CHK("nak", bank[7][4], nak_on_error)
    `CHK("power", bank[7][1:0], power_mode)
    `CHK("mode", tun ? 2'b01 : ext ? 2'b10 : 2'b00, comm_mode)
  endtask : check_outs

  task automatic set_auth(input logic v);
    @(posedge clock) #2;
    tag_selected = v;
    auth_pass = v;
    @(posedge clock) #2;
    auth_pass = 0;
    @(posedge clock) #2;
    `CHK("auth", v, authenticated)
    au = v;
  endtask : set_auth

  // Reader block access; limit at or past the last block means no protection
  task automatic blk(input logic [7:0] a, input logic w, input logic lk);
    logic [7:0] d;
    logic ok;
    d = 8'($urandom);
    ok = !(bank[0] < LB && a > bank[0] && bank[1][w ? 1 : 0] && !au);
    ok = ok && !(w && lk) && !(w && !bank[7][7] && a >= LB - 8'h01);
    @(posedge clock) #2;
    rd_blk_addr = a;
    rd_blk_write = w;
    rd_blk_locked = lk;
    rd_blk_data = d;
    #1 `CHK("blk_allow", ok, rd_blk_allow)
    @(posedge clock) #2;
    if (!w) `CHK("blk_out", ok ? d : 8'h00, rd_blk_out)
  endtask : blk

  task automatic rcfg(input logic w, input logic [2:0] i, input logic [7:0] d);
    logic ok;
    ok = (i < 3'h2) ? (au && bank[7][3]) : bank[7][7];
    @(posedge clock) #2;
    rd_cfg_req = 1;
    rd_cfg_write = w;
    rd_cfg_index = i;
    rd_cfg_wdata = d;
    #1 `CHK("cfg_ok", ok, rd_cfg_ok)
    @(posedge clock) #2;
    rd_cfg_req = 0;
    if (!w) `CHK("cfg_rdata", ok ? bank[i] : 8'h00, rd_cfg_rdata)
    else if (ok) bank[i] = d;
    if (w && ok && i == 3'h7) {tun, ext} = d[6:5];
    check_outs();
  endtask : rcfg

  // Winner first, then the other requester once the winner is done
  task automatic arb(input logic m);
    host(1, 0, 3'h5, {4'h0, m, 3'h0});
    @(posedge clock) #2;
    mem_host_req = 1;
    mem_reader_req = m;
    @(posedge clock) #2;
    mem_reader_req = 1;
    for (int n = 0; n < 20 && !(mem_host_gnt | mem_reader_gnt); n++) @(posedge clock) #2;
    `CHK("arb_first", {!m, m}, {mem_host_gnt, mem_reader_gnt})
    for (int n = 0; n < 20 && !mem_done; n++) @(posedge clock) #2;
    if (m) mem_reader_req = 0;
    else mem_host_req = 0;
    @(posedge clock) #2;
    for (int n = 0; n < 20 && !(mem_host_gnt | mem_reader_gnt); n++) @(posedge clock) #2;
    `CHK("arb_second", {m, !m}, {mem_host_gnt, mem_reader_gnt})
    for (int n = 0; n < 20 && !mem_done; n++) @(posedge clock) #2;
    mem_host_req = 0;
    mem_reader_req = 0;
  endtask : arb

  // Hang guard, far above the expected thousand or so cycles
  initial
  begin
    #2000000;
    mismatches++;
    summarize();
  end

  initial
  begin
    static logic [7:0] lims [5] = '{8'h00, 8'h10, 8'h7E, 8'h7F, 8'hFF};
    static logic [7:0] cfgs [4] = '{8'h80, 8'h88, 8'h08, 8'h00};
    void'($urandom(24));
    repeat (8) @(posedge clock);
    #2 rst_n = 1;
    for (int i = 0; i < 8; i++) host(0, 0, 3'(i), 8'h00);
    check_outs();
    $display("test reset done");
    for (int i = 0; i < 40; i++)
    begin
      host(1, 0, 3'($urandom_range(2, 7)), 8'($urandom));
      check_outs();
    end
    host(1, 1, 3'h7, 8'h60);
    check_outs();
    $display("test outputs done");
    for (int c = 0; c < 20; c++)
    begin
      set_auth(1'(c / 10));
      host(1, 0, 3'h7, (c % 2) ? 8'h80 : 8'h00);
      host(1, 0, 3'h0, lims[c % 5]);
      host(1, 0, 3'h1, 8'($urandom_range(0, 3)));
      blk(lims[c % 5], 1'($urandom), 1'b0);
      blk(lims[c % 5] + 8'h01, 1'($urandom), 1'b0);
      for (int k = 0; k < 6; k++) blk(8'($urandom_range(0, LB)), 1'($urandom), 1'($urandom));
    end
    $display("test blocks done");
    for (int c = 0; c < 8; c++)
    begin
      set_auth(1'(c / 4));
      host(1, 0, 3'h7, cfgs[c % 4]);
      for (int k = 0; k < 4; k++) rcfg(1'($urandom), 3'($urandom), 8'($urandom));
      for (int i = 0; i < 8; i++) host(0, 0, 3'(i), 8'h00);
    end
    $display("test reader config done");
    for (int c = 0; c < 4; c++)
    begin
      host(1, 0, 3'h5, {c[1], 3'($urandom), 4'h0});
      io_supply_pin = c[0];
      field_present = 1;
      repeat (4) @(posedge clock) #2;
      `CHK("mute", c == 2, reader_mute)
      io_supply_pin = !c[0];
      repeat (4) @(posedge clock) #2;
      `CHK("mute_held", c == 2, reader_mute)
      field_present = 0;
      repeat (8) @(posedge clock) #2;
      `CHK("mute_off", 1'b0, reader_mute)
    end
    $display("test quiet mode done");
    arb(1);
    arb(0);
    latency = 4'h3;
    arb(0);
    arb(1);
    $display("test arbitration done");
    summarize();
  end
endmodule : test_tag_config_and_auth_bank

/* File: src/tag_cfg_pkg.sv */
// Types shared by the configuration bank and its bench.
// Assumes nothing beyond a SystemVerilog compiler.
package tag_cfg_pkg;

  typedef enum logic [1:0] {
    mode_standalone = 2'b00,
    mode_tunnel = 2'b01,
    mode_extended = 2'b10
  } comm_mode_e;

  typedef enum logic [1:0] {
    power_mode0 = 2'b00,
    power_mode1 = 2'b01,
    power_mode2 = 2'b10,
    power_mode3 = 2'b11
  } power_mode_e;

  typedef enum logic [1:0] {
    arb_idle = 2'b00,
    arb_host = 2'b01,
    arb_reader = 2'b10
  } arb_state_e;

endpackage : tag_cfg_pkg

/* File: src/tag_cfg_regs.svh */
// Offsets, field positions, reset values and fixed codes of the tag configuration bank.
// Assumes inclusion by bare name from design and bench files alike.
`ifndef TAG_CFG_REGS_SVH
`define TAG_CFG_REGS_SVH

// ****************************************************************
// Byte indices within the configuration bank
// ****************************************************************
`define IDX_PASSWORD_LIMIT_BLOCK 3'h0
`define IDX_PASSWORD_SCOPE 3'h1
`define IDX_REQUEST_ANSWER_HIGH 3'h2
`define IDX_REQUEST_ANSWER_LOW 3'h3
`define IDX_SELECT_ANSWER 3'h4
`define IDX_CHIP_CONFIG_FIRST 3'h5
`define IDX_CHIP_CONFIG_SECOND 3'h6
`define IDX_CHIP_CONFIG_THIRD 3'h7

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_PASSWORD_LIMIT_BLOCK 8'hFF
`define RST_PASSWORD_SCOPE 8'h00
`define RST_REQUEST_ANSWER_HIGH 8'h00
`define RST_REQUEST_ANSWER_LOW 8'h44
`define RST_SELECT_ANSWER 8'h00
`define RST_CHIP_CONFIG_FIRST 8'h00
`define RST_CHIP_CONFIG_SECOND 8'h00
`define RST_CHIP_CONFIG_THIRD 8'h80

// ****************************************************************
// Field positions
// ****************************************************************
`define SCOPE_WRITE_BIT 1
`define SCOPE_READ_BIT 0
`define SEL_CASCADE_BIT 2
`define SEL_FLIP_BIT 6
`define CFG0_QUIET_EN_BIT 7
`define CFG0_QUIET_HI 6
`define CFG0_QUIET_LO 4
`define CFG0_ARBIT_BIT 3
`define CFG0_ADDR_HI 2
`define CFG0_ADDR_LO 0
`define CFG1_RX_CRC_BIT 7
`define CFG2_PERSO_BIT 7
`define CFG2_TUNNEL_BIT 6
`define CFG2_EXTEND_BIT 5
`define CFG2_NAK_BIT 4
`define CFG2_AUTH_SET_BIT 3
`define CFG2_FLIP_BIT 2
`define CFG2_POWER_HI 1
`define CFG2_POWER_LO 0

// ****************************************************************
// Fixed codes and sizes
// ****************************************************************
`define I2C_GROUP 4'hA
`define MSG_MAX_PLAIN 6'h20
`define MSG_MAX_WITH_CRC 6'h1E

`endif

/* File: src/tag_config_and_auth_bank.sv */
// Configuration byte bank with reader access policy, anti-collision answers and modes.
// Assumes host and reader request ports synchronous to clock; supply compare is a pin.
`include "tag_cfg_regs.svh"

// ****************************************************************
// Configuration and authentication bank
// ****************************************************************
// Overview of operation
// RULE1 - Limit byte is block address, resets FFh
// RULE2 - Limit past last block disables protection
// RULE3 - Scope bit1 guards writes, bit0 reads
// RULE4 - Fully protected unauthenticated access gets silence
// RULE5 - Mixed access returns zeros for protected part
// RULE6 - Lock bits refuse writes despite authentication
// RULE7 - Reader touches auth bytes only when authorised
// RULE8 - Request answer is high then low byte
// RULE9 - Select answer forces cascade bit per level
// RULE10 - Personalisation bit resets one, opens config
// RULE11 - Cleared personalisation bars last two blocks
// RULE12 - Quiet mode mutes reader below threshold
// RULE13 - Supply compared when field appears
// RULE14 - Arbitration bit: fair order or reader first
// RULE15 - Host may change arbitration bit live
// RULE16 - I2C address is group plus three bits
// RULE17 - Stored CRC shrinks message to thirty
// RULE18 - CRC checked regardless of store bit
// RULE19 - Mode bits preset host-writable volatile copies
// RULE20 - Power field selects power mode zero-three
// RULE21 - Level two select bit six flips
// RULE22 - Bit four picks CRC/parity error handling
// RULE23 - Leaving selected state drops authentication
// RULE24 - Tunnel wins over extended mode
// RULE25 - Bytes active from reset; host writes both
module tag_config_and_auth_bank #(
  parameter logic [7:0] LAST_BLOCK = 8'h7F
) (
  input wire logic clock,
  input wire logic rst_n,
  // Host port
  input wire logic host_req,
  input wire logic host_write,
  input wire logic host_mode_only,
  input wire logic [2:0] host_index,
  input wire logic [7:0] host_wdata,
  output logic host_grant,
  output logic [7:0] host_rdata,
  // Reader configuration access
  input wire logic rd_cfg_req,
  input wire logic rd_cfg_write,
  input wire logic [2:0] rd_cfg_index,
  input wire logic [7:0] rd_cfg_wdata,
  output logic rd_cfg_ok,
  output logic [7:0] rd_cfg_rdata,
  // Reader block access check
  input wire logic [7:0] rd_blk_addr,
  input wire logic rd_blk_write,
  input wire logic rd_blk_locked,
  input wire logic [7:0] rd_blk_data,
  output logic rd_blk_allow,
  output logic [7:0] rd_blk_out,
  // Session state
  input wire logic auth_pass,
  input wire logic tag_selected,
  input wire logic field_present,
  input wire logic io_supply_pin,
  output logic authenticated,
  output logic reader_mute,
  // Memory arbitration
  input wire logic mem_host_req,
  input wire logic mem_reader_req,
  input wire logic mem_done,
  output logic mem_host_gnt,
  output logic mem_reader_gnt,
  // Anti-collision answers and status
  input wire logic frame_crc_ok,
  output logic [15:0] sens_res,
  output logic [7:0] sel_res_level1,
  output logic [7:0] sel_res_level2,
  output logic [6:0] i2c_address,
  output logic [2:0] quiet_threshold_code,
  output logic crc_store,
  output logic [5:0] msg_max_len,
  output logic crc_error,
  output logic nak_on_error,
  output tag_cfg_pkg::comm_mode_e comm_mode,
  output tag_cfg_pkg::power_mode_e power_mode
);

  // Stored bytes and session flags
  logic [7:0] bank_reg [8];
  logic tunnel_reg;
  logic extend_reg;
  logic auth_reg;
  logic mute_reg;
  logic [1:0] field_sync_reg;
  logic [1:0] supply_sync_reg;
  logic field_seen_reg;
  logic [7:0] host_rdata_reg;
  logic [7:0] rd_cfg_rdata_reg;
  logic [7:0] rd_blk_out_reg;
  logic crc_error_reg;
  tag_cfg_pkg::arb_state_e arb_reg;
  tag_cfg_pkg::arb_state_e arb_next;
  // Decoded access decisions
  logic reader_cfg_allow;
  logic reader_cfg_write;
  logic host_bank_write;
  logic perso_en;
  logic prot_active;
  logic blk_protected;
  logic [7:0] sel_base;

  // Reset image of one byte, decoded only for the bank reset
  function automatic logic [7:0] reset_value(input logic [2:0] idx);
    logic [7:0] v;
    v = `RST_SELECT_ANSWER;
    if (idx == `IDX_PASSWORD_LIMIT_BLOCK) v = `RST_PASSWORD_LIMIT_BLOCK;
    else if (idx == `IDX_PASSWORD_SCOPE) v = `RST_PASSWORD_SCOPE;
    else if (idx == `IDX_REQUEST_ANSWER_HIGH) v = `RST_REQUEST_ANSWER_HIGH;
    else if (idx == `IDX_REQUEST_ANSWER_LOW) v = `RST_REQUEST_ANSWER_LOW;
    else if (idx == `IDX_CHIP_CONFIG_FIRST) v = `RST_CHIP_CONFIG_FIRST;
    else if (idx == `IDX_CHIP_CONFIG_SECOND) v = `RST_CHIP_CONFIG_SECOND;
    else if (idx == `IDX_CHIP_CONFIG_THIRD) v = `RST_CHIP_CONFIG_THIRD;
    return v;
  endfunction : reset_value

  // True for the two bytes that hold the password policy
  function automatic logic is_auth_byte(input logic [2:0] idx);
    return (idx == `IDX_PASSWORD_LIMIT_BLOCK) || (idx == `IDX_PASSWORD_SCOPE);
  endfunction : is_auth_byte

  // ****************************************************************
  // Access policy
  // ****************************************************************
  assign perso_en = bank_reg[`IDX_CHIP_CONFIG_THIRD][`CFG2_PERSO_BIT]; // RULE10
  // Policy bytes need the session plus the settings enable; others need personalisation
  always_comb
  begin
    if (is_auth_byte(rd_cfg_index))
      reader_cfg_allow = auth_reg
        && bank_reg[`IDX_CHIP_CONFIG_THIRD][`CFG2_AUTH_SET_BIT]; // RULE7
    else
      reader_cfg_allow = perso_en; // RULE10 RULE11
  end
  assign reader_cfg_write = rd_cfg_req && rd_cfg_write && reader_cfg_allow && !mute_reg;

  // Host never blocked; mode-only writes leave the stored third byte alone
  assign host_bank_write = host_req && host_write
    && !(host_mode_only && host_index == `IDX_CHIP_CONFIG_THIRD); // RULE25

  // Protection scope for the block being touched
  always_comb
  begin
    prot_active = bank_reg[`IDX_PASSWORD_LIMIT_BLOCK] < LAST_BLOCK; // RULE2
    if (rd_blk_write)
      blk_protected = prot_active
        && bank_reg[`IDX_PASSWORD_SCOPE][`SCOPE_WRITE_BIT]; // RULE3
    else
      blk_protected = prot_active
        && bank_reg[`IDX_PASSWORD_SCOPE][`SCOPE_READ_BIT]; // RULE3
    blk_protected = blk_protected
      && (rd_blk_addr > bank_reg[`IDX_PASSWORD_LIMIT_BLOCK]) && !auth_reg; // RULE1
  end

  // Write refused when locked, protected, muted or in last two blocks after personalisation
  always_comb
  begin
    rd_blk_allow = !blk_protected && !mute_reg; // RULE4
    if (rd_blk_write && rd_blk_locked)
      rd_blk_allow = 1'b0; // RULE6
    if (rd_blk_write && !perso_en && rd_blk_addr >= LAST_BLOCK - 8'h01)
      rd_blk_allow = 1'b0; // RULE11
  end

  // ****************************************************************
  // Configuration storage
  // ****************************************************************
  // One flop bank; when host and reader write the same byte in one cycle, the host wins
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_bank
      always_ff @(posedge clock or negedge rst_n)
      begin
        if (!rst_n)
          bank_reg[gi] <= reset_value(3'(gi)); // RULE1 RULE8 RULE10 RULE25
        else if (host_bank_write && host_index == 3'(gi))
          bank_reg[gi] <= host_wdata; // RULE7 RULE15 RULE25
        else if (reader_cfg_write && rd_cfg_index == 3'(gi))
          bank_reg[gi] <= rd_cfg_wdata;
      end
    end
  endgenerate

  // Volatile mode copies, preset from the stored byte
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tunnel_reg <= 1'(`RST_CHIP_CONFIG_THIRD >> `CFG2_TUNNEL_BIT);
      extend_reg <= 1'(`RST_CHIP_CONFIG_THIRD >> `CFG2_EXTEND_BIT);
    end
    else if (host_req && host_write && host_index == `IDX_CHIP_CONFIG_THIRD)
    begin
      tunnel_reg <= host_wdata[`CFG2_TUNNEL_BIT]; // RULE19
      extend_reg <= host_wdata[`CFG2_EXTEND_BIT]; // RULE19
    end
    else if (reader_cfg_write && rd_cfg_index == `IDX_CHIP_CONFIG_THIRD)
    begin
      tunnel_reg <= rd_cfg_wdata[`CFG2_TUNNEL_BIT];
      extend_reg <= rd_cfg_wdata[`CFG2_EXTEND_BIT];
    end
  end

  // ****************************************************************
  // Session state
  // ****************************************************************
  // Authentication held only while selected; deselect beats a pass in the same cycle
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      auth_reg <= 1'b0;
    else if (!tag_selected)
      auth_reg <= 1'b0; // RULE23
    else if (auth_pass)
      auth_reg <= 1'b1;
  end

  // Pin inputs through two flops before use
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      field_sync_reg <= 2'b00;
      supply_sync_reg <= 2'b00;
    end
    else
    begin
      field_sync_reg <= {field_sync_reg[0], field_present};
      supply_sync_reg <= {supply_sync_reg[0], io_supply_pin};
    end
  end

  // Supply sampled once on field entry; a later dip does not re-mute mid-session
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      field_seen_reg <= 1'b0;
      mute_reg <= 1'b0;
    end
    else
    begin
      field_seen_reg <= field_sync_reg[1];
      if (field_sync_reg[1] && !field_seen_reg)
        mute_reg <= bank_reg[`IDX_CHIP_CONFIG_FIRST][`CFG0_QUIET_EN_BIT]
          && !supply_sync_reg[1]; // RULE12 RULE13
      else if (!field_sync_reg[1])
        mute_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Memory arbitration
  // ****************************************************************
  // Live bit from the bank, so host changes apply at once
  always_comb
  begin
    arb_next = arb_reg;
    case (arb_reg)
      tag_cfg_pkg::arb_idle:
        if (mem_reader_req && (bank_reg[`IDX_CHIP_CONFIG_FIRST][`CFG0_ARBIT_BIT]
            || !mem_host_req))
          arb_next = tag_cfg_pkg::arb_reader; // RULE14 RULE15
        else if (mem_host_req)
          arb_next = tag_cfg_pkg::arb_host; // RULE14
      tag_cfg_pkg::arb_host,
      tag_cfg_pkg::arb_reader:
        if (mem_done)
          arb_next = tag_cfg_pkg::arb_idle;
      default:
        arb_next = tag_cfg_pkg::arb_idle;
    endcase
  end

  // Arbiter state register
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      arb_reg <= tag_cfg_pkg::arb_idle;
    else
      arb_reg <= arb_next;
  end

  // Grants decode the state
  assign mem_host_gnt = (arb_reg == tag_cfg_pkg::arb_host);
  assign mem_reader_gnt = (arb_reg == tag_cfg_pkg::arb_reader);

  // ****************************************************************
  // Read data
  // ****************************************************************
  // Registered read paths; zero stands in for protected bytes
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      host_rdata_reg <= 8'h00;
      rd_cfg_rdata_reg <= 8'h00;
      rd_blk_out_reg <= 8'h00;
      crc_error_reg <= 1'b0;
    end
    else
    begin
      if (host_req && !host_write)
        host_rdata_reg <= bank_reg[host_index];
      if (rd_cfg_req && !rd_cfg_write)
        rd_cfg_rdata_reg <= reader_cfg_allow ? bank_reg[rd_cfg_index] : 8'h00;
      rd_blk_out_reg <= blk_protected ? 8'h00 : rd_blk_data; // RULE5
      crc_error_reg <= !frame_crc_ok; // RULE18
    end
  end

  // Handshakes combinational, data from flops
  assign host_grant = host_req;
  assign host_rdata = host_rdata_reg;
  assign rd_cfg_ok = rd_cfg_req && reader_cfg_allow && !mute_reg;
  assign rd_cfg_rdata = rd_cfg_rdata_reg;
  assign rd_blk_out = rd_blk_out_reg;
  assign authenticated = auth_reg;
  assign reader_mute = mute_reg;
  assign crc_error = crc_error_reg;

  // ****************************************************************
  // Derived settings
  // ****************************************************************
  // Anti-collision answers
  assign sens_res = {bank_reg[`IDX_REQUEST_ANSWER_HIGH],
    bank_reg[`IDX_REQUEST_ANSWER_LOW]}; // RULE8

  // Cascade bit forced per level
  always_comb
  begin
    sel_base = bank_reg[`IDX_SELECT_ANSWER];
    sel_res_level1 = sel_base;
    sel_res_level1[`SEL_CASCADE_BIT] = 1'b1; // RULE9
    sel_res_level2 = sel_base;
    sel_res_level2[`SEL_CASCADE_BIT] = 1'b0; // RULE9
    if (bank_reg[`IDX_CHIP_CONFIG_THIRD][`CFG2_FLIP_BIT])
      sel_res_level2[`SEL_FLIP_BIT] = !sel_base[`SEL_FLIP_BIT]; // RULE21
  end

  // Fields taken straight from the bytes
  assign i2c_address = {`I2C_GROUP,
    bank_reg[`IDX_CHIP_CONFIG_FIRST][`CFG0_ADDR_HI:`CFG0_ADDR_LO]}; // RULE16
  assign quiet_threshold_code =
    bank_reg[`IDX_CHIP_CONFIG_FIRST][`CFG0_QUIET_HI:`CFG0_QUIET_LO];
  assign crc_store = bank_reg[`IDX_CHIP_CONFIG_SECOND][`CFG1_RX_CRC_BIT]; // RULE17
  assign msg_max_len = crc_store ? `MSG_MAX_WITH_CRC : `MSG_MAX_PLAIN; // RULE17
  assign nak_on_error = bank_reg[`IDX_CHIP_CONFIG_THIRD][`CFG2_NAK_BIT]; // RULE22
  // Power field maps one to one
  assign power_mode = tag_cfg_pkg::power_mode_e'(
    bank_reg[`IDX_CHIP_CONFIG_THIRD][`CFG2_POWER_HI:`CFG2_POWER_LO]); // RULE20

  // Tunnel takes priority when both copies are set
  always_comb
  begin
    if (tunnel_reg)
      comm_mode = tag_cfg_pkg::mode_tunnel; // RULE24
    else if (extend_reg)
      comm_mode = tag_cfg_pkg::mode_extended;
    else
      comm_mode = tag_cfg_pkg::mode_standalone;
  end

endmodule : tag_config_and_auth_bank
